// ===== dmr_consts.vh
// Purpose: Shared constants for the drive monitor readout block
// Assumes: 32-bit classic Wishbone, byte addresses, one word per register
// Notes:   Offsets, field positions, reset values and timing figures
`ifndef DMR_CONSTS_VH
`define DMR_CONSTS_VH

// Register byte offsets
`define DMR_CTRL_OFS        8'h00
`define DMR_PPM_OFS         8'h04
`define DMR_HOST_FREQ_OFS   8'h08
`define DMR_AI1_CORR_OFS    8'h10
`define DMR_AI2_CORR_OFS    8'h14
`define DMR_AI3_CORR_OFS    8'h18
`define DMR_AI1_RAW_OFS     8'h1C
`define DMR_AI2_RAW_OFS     8'h20
`define DMR_AI3_RAW_OFS     8'h24
`define DMR_PID_SET_OFS     8'h28
`define DMR_PID_FB_OFS      8'h2C
`define DMR_PULSE_CHZ_OFS   8'h30
`define DMR_PULSE_HZ_OFS    8'h34
`define DMR_SPEED_FB_OFS    8'h38
`define DMR_ENC_SPEED_OFS   8'h3C
`define DMR_LIN_SPEED_OFS   8'h40
`define DMR_ROTOR_ANG_OFS   8'h44
`define DMR_RESOLVER_OFS    8'h48
`define DMR_QUAD_POS_OFS    8'h4C
`define DMR_REMAIN_OFS      8'h50
`define DMR_MOTOR_TEMP_OFS  8'h54
`define DMR_VF_TARGET_OFS   8'h58
`define DMR_VF_ACTUAL_OFS   8'h5C
`define DMR_TORQUE_OFS      8'h60
`define DMR_OUT_STATE_OFS   8'h64

// Control register fields
`define DMR_CTRL_AI2_UNIT_BIT  0
`define DMR_CTRL_RES_LSB       1
`define DMR_CTRL_RES_MSB       2
`define DMR_CTRL_TEMP_EN_BIT   3

// Reset values
`define DMR_CTRL_RST       4'h4
`define DMR_PPM_RST        16'h0001
`define DMR_HOST_FREQ_RST  16'h0000

// Encodings and limits
`define DMR_RES_ONE_DIGIT  2'h1
`define DMR_RES_TWO_DIGIT  2'h2
`define DMR_PULSE_MAX_HZ   17'd100000
`define DMR_ANGLE_MAX      16'd3599
`define DMR_REMAIN_MAX     16'd65000
`define DMR_TEMP_MAX       16'd200
`define DMR_TORQUE_MAX     16'sd2000
`define DMR_PCT_FULL       16'd10000

// Timing
`define DMR_CLK_FREQ_MHZ   100
`define DMR_GATE_TIME_MS   1000

`endif

// ===== dmr_monitor.v
// Purpose: Read-only drive monitor readout with a classic Wishbone slave
// Assumes: All inputs synchronous to clk_i; one clock domain
// Notes:   Monitor registers refresh every cycle from their sources, except the pulse rate, which refreshes once per gate
//
// Overview of operation
// - Second analog input reads in volts when unit select is 0, milliamps when 1.
// - PID setpoint and feedback are separate 0..65535 values scaled from percent.
// - Pulse input frequency is measured and reported in 0.01 kHz steps to 100 kHz.
// - Same pulse frequency is also reported with 1 Hz resolution up to 100 kHz.
// - Speed feedback has one fraction digit at resolution 1, two at resolution 2.
// - Encoder-derived signed motor speed is separate from the actual output frequency.
// - Linear speed equals pulses per minute divided by pulses per metre.
// - Last host write to the frequency setting is echoed as signed percent.
// - Rotor angle reported in tenth degrees, 0.0 to 359.9.
// - Resolver angle reported unsigned, 0 to 4095.
// - Quadrature count advances four counts per encoder pulse, every edge of both phases.
// - Quadrature count increments forward and decrements in reverse.
// - Quadrature count wraps 65535 to 0 and 0 to 65535, no saturation.
// - Each analog input exposes raw sample and corrected value side by side.
// - Remaining run time in tenth minutes up to 6500.0 while timed operation runs.
// - Motor temperature 0..200 C derived from third analog input samples.
// - Target and actual output voltage reported during independent voltage control.
// - Target torque reported signed, -200.0 to +200.0 percent.
// - Output state word has one bit per output, one meaning high level.
`timescale 1ns/1ns
`include "dmr_consts.vh"
`default_nettype none

module dmr_monitor #(
  parameter GATE_CYCLES = `DMR_GATE_TIME_MS * `DMR_CLK_FREQ_MHZ * 1000,
  parameter TEMP_DIV = 5,
  parameter OUT_W = 10
) (
  input wire clk_i,
  input wire rst_i,
  // Wishbone slave
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_we_i,
  input wire [7:0] wb_adr_i,
  input wire [3:0] wb_sel_i,
  input wire [31:0] wb_dat_i,
  output reg [31:0] wb_dat_o,
  output reg wb_ack_o,
  // Pins
  input wire pulse_capable_input_i,
  input wire enc_phase_a_i,
  input wire enc_phase_b_i,
  // Analog samples, 0.01 V or 0.01 mA units
  input wire [15:0] analog_in_one_raw_i,
  input wire [15:0] analog_in_one_corr_i,
  input wire [15:0] analog_in_two_volt_raw_i,
  input wire [15:0] analog_in_two_volt_corr_i,
  input wire [15:0] analog_in_two_ma_raw_i,
  input wire [15:0] analog_in_two_ma_corr_i,
  input wire [15:0] analog_in_three_raw_i,
  input wire [15:0] analog_in_three_corr_i,
  // Computed quantities from the drive core
  input wire [15:0] pid_setpoint_pct_i,
  input wire [15:0] pid_feedback_pct_i,
  input wire [31:0] speed_feedback_chz_i,
  input wire [31:0] encoder_speed_chz_i,
  input wire [15:0] rotor_angle_i,
  input wire [11:0] resolver_angle_i,
  input wire timed_run_enable_i,
  input wire [15:0] remaining_time_i,
  input wire vf_separate_i,
  input wire [15:0] vf_target_volt_i,
  input wire [15:0] vf_actual_volt_i,
  input wire [15:0] target_torque_i,
  input wire [OUT_W-1:0] output_levels_i
);

  // Control and configuration registers
  reg [3:0] ctrl_reg;
  reg [15:0] ppm_reg;
  reg [15:0] host_freq_reg;
  // Bus
  reg [31:0] dat_next;
  wire bus_req;
  wire bus_wr;
  // Pulse measurement
  reg pulse_prev_reg;
  reg [31:0] gate_cnt_reg;
  reg [16:0] edge_cnt_reg;
  reg [16:0] pulse_hz_reg;
  reg [15:0] lin_speed_reg;
  wire pulse_rise;
  wire gate_end;
  reg [16:0] edge_sum;
  wire [31:0] pulses_per_min;
  reg [31:0] lin_quot;
  // Quadrature
  reg enc_a_prev_reg;
  reg enc_b_prev_reg;
  reg [15:0] quad_pos_reg;
  wire a_chg;
  wire b_chg;
  wire quad_up;
  // Derived monitor values
  wire ai2_ma;
  wire [1:0] freq_res;
  reg [31:0] pid_set_scaled;
  reg [31:0] pid_fb_scaled;
  reg [31:0] speed_fb_fmt;
  reg [31:0] enc_speed_fmt;
  reg [15:0] angle_clamped;
  reg [15:0] remain_val;
  wire [15:0] temp_raw;
  reg [15:0] temp_val;
  reg [15:0] torque_val;
  wire [OUT_W-1:0] out_state;

  assign ai2_ma = ctrl_reg[`DMR_CTRL_AI2_UNIT_BIT];
  assign freq_res = ctrl_reg[`DMR_CTRL_RES_MSB:`DMR_CTRL_RES_LSB];

  // Accepted on the first cycle of a request; ack blocks a second acceptance
  assign bus_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  // A write lands on the edge where the master samples ack, while it still
  // holds address and data; a master that gives up early changes nothing
  assign bus_wr = wb_cyc_i & wb_stb_i & wb_we_i & wb_ack_o;

  // Writable configuration; monitor offsets have no write path
  always @(posedge clk_i) begin
    if (rst_i) begin
      ctrl_reg <= `DMR_CTRL_RST;
      ppm_reg <= `DMR_PPM_RST;
      host_freq_reg <= `DMR_HOST_FREQ_RST;
    end else if (bus_wr) begin
      case (wb_adr_i)
        `DMR_CTRL_OFS: begin
          if (wb_sel_i[0]) begin
            ctrl_reg <= wb_dat_i[3:0];
          end
        end
        `DMR_PPM_OFS: begin
          if (wb_sel_i[0]) begin
            ppm_reg[7:0] <= wb_dat_i[7:0];
          end
          if (wb_sel_i[1]) begin
            ppm_reg[15:8] <= wb_dat_i[15:8];
          end
        end
        `DMR_HOST_FREQ_OFS: begin
          if (wb_sel_i[0]) begin
            host_freq_reg[7:0] <= wb_dat_i[7:0];
          end
          if (wb_sel_i[1]) begin
            host_freq_reg[15:8] <= wb_dat_i[15:8];
          end
        end
        default: begin
          ctrl_reg <= ctrl_reg;
        end
      endcase
    end
  end

  // Pulse frequency: count rising edges over a fixed gate, result in Hz
  // With the one-second default gate the edge count is the rate directly;
  // a shorter gate trades resolution for a faster update
  assign pulse_rise = pulse_capable_input_i & ~pulse_prev_reg;
  assign gate_end = (gate_cnt_reg == GATE_CYCLES - 1);

  // Count saturates so a runaway input cannot wrap into a small reading
  always @* begin
    if (edge_cnt_reg >= `DMR_PULSE_MAX_HZ) begin
      edge_sum = `DMR_PULSE_MAX_HZ;
    end else begin
      edge_sum = edge_cnt_reg + {16'h0000, pulse_rise};
    end
  end

  always @(posedge clk_i) begin
    if (rst_i) begin
      pulse_prev_reg <= 1'b0;
      gate_cnt_reg <= 32'h0000_0000;
      edge_cnt_reg <= 17'h0_0000;
      pulse_hz_reg <= 17'h0_0000;
    end else begin
      pulse_prev_reg <= pulse_capable_input_i;
      if (gate_end) begin
        gate_cnt_reg <= 32'h0000_0000;
        edge_cnt_reg <= 17'h0_0000;
        pulse_hz_reg <= edge_sum;
      end else begin
        gate_cnt_reg <= gate_cnt_reg + 32'h0000_0001;
        edge_cnt_reg <= edge_sum;
      end
    end
  end

  // Linear speed from last measurement; a zero divisor reads as zero
  // The divider is combinational: a long path traded for no extra state
  assign pulses_per_min = {15'h0000, pulse_hz_reg} * 32'd60;
  always @* begin
    if (ppm_reg == 16'h0000) begin
      lin_quot = 32'h0000_0000;
    end else begin
      lin_quot = pulses_per_min / {16'h0000, ppm_reg};
    end
  end

  always @(posedge clk_i) begin
    if (rst_i) begin
      lin_speed_reg <= 16'h0000;
    end else if (lin_quot > 32'h0000_FFFF) begin
      lin_speed_reg <= 16'hFFFF;
    end else begin
      lin_speed_reg <= lin_quot[15:0];
    end
  end

  // Quadrature decode: any single-phase edge is one count; both at once is noise
  // A skipped state loses counts rather than being guessed as a direction
  assign a_chg = enc_phase_a_i ^ enc_a_prev_reg;
  assign b_chg = enc_phase_b_i ^ enc_b_prev_reg;
  assign quad_up = enc_phase_a_i ^ enc_b_prev_reg;

  always @(posedge clk_i) begin
    if (rst_i) begin
      enc_a_prev_reg <= 1'b0;
      enc_b_prev_reg <= 1'b0;
      quad_pos_reg <= 16'h0000;
    end else begin
      enc_a_prev_reg <= enc_phase_a_i;
      enc_b_prev_reg <= enc_phase_b_i;
      if (a_chg ^ b_chg) begin
        if (quad_up) begin
          quad_pos_reg <= quad_pos_reg + 16'h0001;
        end else begin
          quad_pos_reg <= quad_pos_reg - 16'h0001;
        end
      end
    end
  end

  // Percent in 0.01 % steps mapped onto the full 16-bit range; full scale and
  // above pin to the top so the product never needs more than 32 bits
  always @* begin
    if (pid_setpoint_pct_i >= `DMR_PCT_FULL) begin
      pid_set_scaled = 32'h0000_FFFF;
    end else begin
      pid_set_scaled = ({16'h0000, pid_setpoint_pct_i} * 32'd65535) / 32'd10000;
    end
    if (pid_feedback_pct_i >= `DMR_PCT_FULL) begin
      pid_fb_scaled = 32'h0000_FFFF;
    end else begin
      pid_fb_scaled = ({16'h0000, pid_feedback_pct_i} * 32'd65535) / 32'd10000;
    end
  end

  // Speeds arrive in 0.01 Hz; one-digit resolution drops a decimal place
  // The divide keeps both operands signed so reverse speeds truncate toward zero
  always @* begin
    if (freq_res == `DMR_RES_ONE_DIGIT) begin
      speed_fb_fmt = $signed(speed_feedback_chz_i) / 32'sd10;
      enc_speed_fmt = $signed(encoder_speed_chz_i) / 32'sd10;
    end else begin
      speed_fb_fmt = speed_feedback_chz_i;
      enc_speed_fmt = encoder_speed_chz_i;
    end
  end

  // Rotor angle held inside one turn of tenth-degree steps
  always @* begin
    if (rotor_angle_i > `DMR_ANGLE_MAX) begin
      angle_clamped = `DMR_ANGLE_MAX;
    end else begin
      angle_clamped = rotor_angle_i;
    end
  end

  // Remaining time reads zero whenever timed operation is off
  always @* begin
    if (!timed_run_enable_i) begin
      remain_val = 16'h0000;
    end else if (remaining_time_i > `DMR_REMAIN_MAX) begin
      remain_val = `DMR_REMAIN_MAX;
    end else begin
      remain_val = remaining_time_i;
    end
  end

  // Temperature only meaningful with the sensor configured on the third input
  // Limitation: a negative sample divides as a large value and reads the top
  assign temp_raw = analog_in_three_corr_i / TEMP_DIV[15:0];
  always @* begin
    if (!ctrl_reg[`DMR_CTRL_TEMP_EN_BIT]) begin
      temp_val = 16'h0000;
    end else if (temp_raw > `DMR_TEMP_MAX) begin
      temp_val = `DMR_TEMP_MAX;
    end else begin
      temp_val = temp_raw;
    end
  end

  // Torque clamped symmetrically in tenth percent; compares are signed
  always @* begin
    if ($signed(target_torque_i) > `DMR_TORQUE_MAX) begin
      torque_val = `DMR_TORQUE_MAX;
    end else if ($signed(target_torque_i) < -`DMR_TORQUE_MAX) begin
      torque_val = 16'h0000 - `DMR_TORQUE_MAX;
    end else begin
      torque_val = target_torque_i;
    end
  end

  // One state bit per output, 1 for a high pin and 0 for a low one
  // The loop keeps the bit mapping explicit when OUT_W changes
  genvar out_idx;
  generate
    for (out_idx = 0; out_idx < OUT_W; out_idx = out_idx + 1) begin : g_out_bit
      assign out_state[out_idx] = output_levels_i[out_idx];
    end
  endgenerate

  // Read mux; unmapped offsets read zero
  // Most values come live from the inputs at the request edge; pulse, linear speed and quadrature words come from registers
  always @* begin
    dat_next = 32'h0000_0000;
    case (wb_adr_i)
      `DMR_CTRL_OFS: dat_next = {28'h000_0000, ctrl_reg};
      `DMR_PPM_OFS: dat_next = {16'h0000, ppm_reg};
      `DMR_HOST_FREQ_OFS: dat_next = {{16{host_freq_reg[15]}}, host_freq_reg};
      `DMR_AI1_CORR_OFS: dat_next = {16'h0000, analog_in_one_corr_i};
      `DMR_AI2_CORR_OFS: dat_next = {16'h0000, ai2_ma ? analog_in_two_ma_corr_i :
                                     analog_in_two_volt_corr_i};
      `DMR_AI3_CORR_OFS: dat_next = {{16{analog_in_three_corr_i[15]}},
                                     analog_in_three_corr_i};
      `DMR_AI1_RAW_OFS: dat_next = {16'h0000, analog_in_one_raw_i};
      `DMR_AI2_RAW_OFS: dat_next = {16'h0000, ai2_ma ? analog_in_two_ma_raw_i :
                                    analog_in_two_volt_raw_i};
      `DMR_AI3_RAW_OFS: dat_next = {{16{analog_in_three_raw_i[15]}},
                                    analog_in_three_raw_i};
      `DMR_PID_SET_OFS: dat_next = pid_set_scaled;
      `DMR_PID_FB_OFS: dat_next = pid_fb_scaled;
      `DMR_PULSE_CHZ_OFS: dat_next = {15'h0000, pulse_hz_reg / 17'd10};
      `DMR_PULSE_HZ_OFS: dat_next = {15'h0000, pulse_hz_reg};
      `DMR_SPEED_FB_OFS: dat_next = speed_fb_fmt;
      `DMR_ENC_SPEED_OFS: dat_next = enc_speed_fmt;
      `DMR_LIN_SPEED_OFS: dat_next = {16'h0000, lin_speed_reg};
      `DMR_ROTOR_ANG_OFS: dat_next = {16'h0000, angle_clamped};
      `DMR_RESOLVER_OFS: dat_next = {20'h0_0000, resolver_angle_i};
      `DMR_QUAD_POS_OFS: dat_next = {16'h0000, quad_pos_reg};
      `DMR_REMAIN_OFS: dat_next = {16'h0000, remain_val};
      `DMR_MOTOR_TEMP_OFS: dat_next = {16'h0000, temp_val};
      `DMR_VF_TARGET_OFS: dat_next = {16'h0000, vf_separate_i ? vf_target_volt_i :
                                      16'h0000};
      `DMR_VF_ACTUAL_OFS: dat_next = {16'h0000, vf_separate_i ? vf_actual_volt_i :
                                      16'h0000};
      `DMR_TORQUE_OFS: dat_next = {{16{torque_val[15]}}, torque_val};
      `DMR_OUT_STATE_OFS: dat_next = {{(32-OUT_W){1'b0}}, out_state};
      default: dat_next = 32'h0000_0000;
    endcase
  end

  // Ack one cycle after the request is seen, then drop; data captured with it
  // Writes leave the read data alone, so it holds until the next read
  always @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      wb_ack_o <= bus_req;
      if (bus_req && !wb_we_i) begin
        wb_dat_o <= dat_next;
      end
    end
  end

endmodule // dmr_monitor

`default_nettype wire

// ===== dmr_monitor_properties.sv
// Purpose: Concurrent checks on the monitor's Wishbone answers
// Assumes: One clock, synchronous active-high reset
// Notes: Read values are tied to the inputs seen at the request edge
`timescale 1ns/1ns
`include "dmr_consts.vh"
`default_nettype none
module dmr_monitor_properties #(
  parameter int OUT_W = 10
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  input wire logic [15:0] pid_setpoint_pct_i,
  input wire logic [11:0] resolver_angle_i,
  input wire logic timed_run_enable_i,
  input wire logic [OUT_W-1:0] output_levels_i
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // Requests as the slave takes them; ack low keeps a held cycle from counting twice
  wire req = wb_cyc_i && wb_stb_i && !wb_ack_o;
  wire rd = req && !wb_we_i;
  // Full scale of 10000 maps onto 65535
  function automatic logic [31:0] pidx(input logic [15:0] p);
    return p >= 16'd10000 ? 32'h0000_FFFF : 32'(p) * 32'd65535 / 32'd10000;
  endfunction
  a_ack_follows: assert property (req |=> wb_ack_o) else $error("no ack");
  a_ack_cause: assert property ($rose(wb_ack_o) |-> $past(req)) else $error("stray ack");
  a_ack_single: assert property (wb_ack_o |=> !wb_ack_o) else $error("long ack");
  a_data_holds: assert property (!wb_ack_o |-> $stable(wb_dat_o)) else $error("data moved");
  a_resolver_read: assert property (rd && wb_adr_i == `DMR_RESOLVER_OFS |=>
    wb_dat_o == {20'h0_0000, $past(resolver_angle_i)}) else $error("resolver");
  a_pid_scaled: assert property (rd && wb_adr_i == `DMR_PID_SET_OFS |=>
    wb_dat_o == pidx($past(pid_setpoint_pct_i))) else $error("pid setpoint");
  a_outputs_read: assert property (rd && wb_adr_i == `DMR_OUT_STATE_OFS |=>
    wb_dat_o == 32'($past(output_levels_i))) else $error("output state");
  a_remain_gated: assert property (rd && wb_adr_i == `DMR_REMAIN_OFS && !timed_run_enable_i
    |=> wb_dat_o == 32'h0) else $error("remaining time");
  a_rotor_bound: assert property (rd && wb_adr_i == `DMR_ROTOR_ANG_OFS |=>
    wb_dat_o <= 32'd3599) else $error("rotor angle");
  a_torque_bound: assert property (rd && wb_adr_i == `DMR_TORQUE_OFS |=>
    $signed(wb_dat_o) >= -2000 && $signed(wb_dat_o) <= 2000) else $error("torque");
  a_temp_bound: assert property (rd && wb_adr_i == `DMR_MOTOR_TEMP_OFS |=>
    wb_dat_o <= 32'd200) else $error("temperature");
  a_pulse_bound: assert property (rd && wb_adr_i == `DMR_PULSE_HZ_OFS |=>
    wb_dat_o <= 32'd100000) else $error("pulse rate");
  a_unmapped_zero: assert property (rd && wb_adr_i == 8'h7C |=> wb_dat_o == 32'h0)
    else $error("unmapped read");
endmodule // dmr_monitor_properties
bind dmr_monitor dmr_monitor_properties #(.OUT_W(OUT_W)) u_chk (.clk_i(clk_i), .rst_i(rst_i),
  .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
  .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .pid_setpoint_pct_i(pid_setpoint_pct_i),
  .resolver_angle_i(resolver_angle_i), .timed_run_enable_i(timed_run_enable_i),
  .output_levels_i(output_levels_i));
`default_nettype wire

// ===== dmr_host.sv
// Purpose: Host model that reads and writes the monitor over Wishbone
// Assumes: Classic single cycles, one idle cycle between them
// Notes: Released write data is inverted so stale values cannot pass
`timescale 1ns/1ns
`default_nettype none
module dmr_host (
  input wire logic clk_i,
  input wire logic ack_i,
  input wire logic [31:0] dat_i,
  output logic cyc_o,
  output logic stb_o,
  output logic we_o,
  output logic [7:0] adr_o,
  output logic [3:0] sel_o,
  output logic [31:0] dat_o
);
  initial {cyc_o, stb_o, we_o, adr_o, sel_o, dat_o} = '0;
  // One cycle; ok stays low when no answer came within the bound
  task automatic xfer(input logic w, input logic [7:0] a, input logic [3:0] s,
                      input logic [31:0] d, output logic [31:0] q, output logic ok);
    int n;
    n = 0;
    @(posedge clk_i);
    {cyc_o, stb_o, we_o, adr_o, sel_o, dat_o} <= {2'b11, w, a, s, d};
    do begin
      @(posedge clk_i);
      n++;
    end while (ack_i !== 1'b1 && n < 50);
    ok = (ack_i === 1'b1);
    q = dat_i;
    {cyc_o, stb_o} <= 2'b00;
    dat_o <= ~d;
  endtask
endmodule // dmr_host
`default_nettype wire

// ===== tb_drive_monitor_readout.sv
// Purpose: Self-checking bench for the drive monitor readout
// Assumes: Gate window shortened to 1000 cycles
// Notes: Expected values come from a model kept in integers
`timescale 1ns/1ns
`include "dmr_consts.vh"
`default_nettype none
module tb_drive_monitor_readout;
  logic clk_i, rst_i, cyc, stb, we, ack, vf, tim, pulse, pulse_en;
  logic [7:0] adr;
  logic [3:0] sel;
  logic [31:0] wd, rdat, spd, enc;
  logic [15:0] ai [8];
  logic [15:0] m [7];
  logic [11:0] res;
  logic [9:0] lev;
  logic [1:0] ph;
  int fails = 0, cmp_count = 0, q = 0, hz = 0, ctrl = 4, ppm = 1, hf = 0, cyc_n = 0;
  localparam logic [7:0] ALL [26] = '{8'h00, 8'h04, 8'h08, 8'h10, 8'h14, 8'h18, 8'h1C,
    8'h20, 8'h24, 8'h28, 8'h2C, 8'h30, 8'h34, 8'h38, 8'h3C, 8'h40, 8'h44, 8'h48, 8'h4C,
    8'h50, 8'h54, 8'h58, 8'h5C, 8'h60, 8'h64, 8'h7C};
  dmr_host h (.clk_i(clk_i), .ack_i(ack), .dat_i(rdat), .cyc_o(cyc), .stb_o(stb),
    .we_o(we), .adr_o(adr), .sel_o(sel), .dat_o(wd));
  dmr_monitor #(.GATE_CYCLES(1000)) dut_u (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wd),
    .wb_dat_o(rdat), .wb_ack_o(ack), .pulse_capable_input_i(pulse),
    .enc_phase_a_i(ph[1] ^ ph[0]), .enc_phase_b_i(ph[1]), .analog_in_one_raw_i(ai[0]),
    .analog_in_one_corr_i(ai[1]), .analog_in_two_volt_raw_i(ai[2]),
    .analog_in_two_volt_corr_i(ai[3]), .analog_in_two_ma_raw_i(ai[4]),
    .analog_in_two_ma_corr_i(ai[5]), .analog_in_three_raw_i(ai[6]),
    .analog_in_three_corr_i(ai[7]), .pid_setpoint_pct_i(m[0]), .pid_feedback_pct_i(m[1]),
    .speed_feedback_chz_i(spd), .encoder_speed_chz_i(enc), .rotor_angle_i(m[2]),
    .resolver_angle_i(res), .timed_run_enable_i(tim), .remaining_time_i(m[3]),
    .vf_separate_i(vf), .vf_target_volt_i(m[4]), .vf_actual_volt_i(m[5]),
    .target_torque_i(m[6]), .output_levels_i(lev));
  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end
  // Pulse pin with a 10-cycle period: 100 rising edges in every full window once pulse_en is set
  always @(posedge clk_i) begin
    cyc_n <= cyc_n + 1;
    pulse <= pulse_en && (cyc_n % 10 < 5);
  end
  function automatic int lim(input int x, input int y);
    return x > y ? y : x;
  endfunction
  function automatic int sp(input logic [31:0] x);
    return ctrl[2:1] == 1 ? $signed(x) / 10 : $signed(x);
  endfunction
  function automatic int pidv(input int x);
    return x >= 10000 ? 65535 : x * 65535 / 10000;
  endfunction
  function automatic logic [31:0] expv(input logic [7:0] a);
    int t;
    t = $signed(m[6]);
    case (a)
      8'h00: return ctrl;
      8'h04: return ppm;
      8'h08: return hf;
      8'h10: return ai[1];
      8'h14: return ctrl[0] ? ai[5] : ai[3];
      8'h18: return $signed(ai[7]);
      8'h1C: return ai[0];
      8'h20: return ctrl[0] ? ai[4] : ai[2];
      8'h24: return $signed(ai[6]);
      8'h28: return pidv(m[0]);
      8'h2C: return pidv(m[1]);
      8'h30: return hz / 10;
      8'h34: return hz;
      8'h38: return sp(spd);
      8'h3C: return sp(enc);
      8'h40: return ppm == 0 ? 0 : lim(hz * 60 / ppm, 65535);
      8'h44: return lim(m[2], 3599);
      8'h48: return res;
      8'h4C: return q;
      8'h50: return tim ? lim(m[3], 65000) : 0;
      8'h54: return ctrl[3] ? lim(ai[7] / 5, 200) : 0;
      8'h58: return vf ? m[4] : 0;
      8'h5C: return vf ? m[5] : 0;
      8'h60: return t > 2000 ? 2000 : (t < -2000 ? -2000 : t);
      8'h64: return lev;
      default: return 0;
    endcase
  endfunction
  // One bus cycle; reads are compared with the model
  task automatic acc(input logic w, input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic ok;
    h.xfer(w, a, 4'hF, d, r, ok);
    cmp_count++;
    if (!ok || (!w && r !== expv(a))) begin
      fails++;
      $display("unexpected at %0t: adr %h read %h", $time, a, r);
      if (!ok) summarize();
    end
  endtask
  task automatic rd_all();
    foreach (ALL[i]) acc(1'b0, ALL[i], 32'h0);
  endtask
  // One phase edge per step, two cycles apart so each edge stands alone
  task automatic quad(input int dir, input int n);
    repeat (n) begin
      @(posedge clk_i);
      ph <= ph + 2'(dir);
      q = (q + dir) & 16'hFFFF;
      @(posedge clk_i);
    end
  endtask
  task automatic summarize();
    $display("comparisons %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  initial begin
    void'($urandom(10));
    rst_i = 1'b1;
    {pulse, pulse_en, ph, vf, tim, spd, enc, res, lev} = '0;
    ai = '{default: 16'h0000};
    m = '{default: 16'h0000};
    repeat (10) @(posedge clk_i);
    rst_i <= 1'b0;
    rd_all();
    $display("test reset done");
    // Control values walk both units, both resolutions and the sensor enable
    for (int r = 0; r < 8; r++) begin
      @(posedge clk_i);
      foreach (ai[i]) ai[i] <= 16'(i == 7 ? $urandom_range(0, 1500) : $urandom);
      foreach (m[i]) m[i] <= 16'($urandom);
      {spd, enc, res, lev, vf, tim} <= {$urandom, $urandom, 24'($urandom)};
      ctrl = (r * 3) & 15;
      acc(1'b1, 8'h00, {28'($urandom), 4'(ctrl)});
      acc(1'b1, ALL[4 + r], 32'($urandom));
      rd_all();
    end
    $display("test modes done");
    ppm = 7;
    hf = 32'hFFFF_8123;
    acc(1'b1, 8'h04, 32'h0000_0007);
    acc(1'b1, 8'h08, 32'h1234_8123);
    acc(1'b0, 8'h08, 32'h0);
    pulse_en <= 1'b1;
    repeat (2500) @(posedge clk_i);
    hz = 100;
    acc(1'b0, 8'h30, 32'h0);
    acc(1'b0, 8'h34, 32'h0);
    acc(1'b0, 8'h40, 32'h0);
    $display("test pulse done");
    quad(-1, 1);
    acc(1'b0, 8'h4C, 32'h0);
    quad(1, 4);
    acc(1'b0, 8'h4C, 32'h0);
    quad(-1, 6);
    acc(1'b0, 8'h4C, 32'h0);
    $display("test quadrature done");
    summarize();
  end
endmodule // tb_drive_monitor_readout
`default_nettype wire
